// [src/fcfs_pkg.sv]
// Package with constants and carrier types for the flash config and flag status block.
package fcfs_pkg;
  // Command opcodes.
  localparam logic [7:0] OP_READ_FLAG   = 8'h70;
  localparam logic [7:0] OP_CLEAR_FLAG  = 8'h50;
  localparam logic [7:0] OP_WRITE_EVCFG = 8'h61;
  localparam logic [7:0] OP_READ_EVCFG  = 8'h65;
  localparam logic [7:0] OP_WRITE_EN    = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS   = 8'h04;
  // Enhanced volatile configuration field positions and reset value.
  localparam int          EV_QUAD_BIT  = 7;
  localparam int          EV_DUAL_BIT  = 6;
  localparam int          EV_RSV_BIT   = 5;
  localparam int          EV_HOLD_BIT  = 4;
  localparam int          EV_ACCEL_BIT = 3;
  localparam logic [7:0]  EV_RESET     = 8'hdf;
  localparam logic [2:0]  DRV_RSV_A    = 3'h0;
  localparam logic [2:0]  DRV_RSV_B    = 3'h4;
  localparam logic [2:0]  DRV_DEFAULT  = 3'h7;
  // Flag status bit positions.
  localparam int FS_READY   = 7;
  localparam int FS_ERS_SUS = 6;
  localparam int FS_ERS_ERR = 5;
  localparam int FS_PGM_ERR = 4;
  localparam int FS_VPP_ERR = 3;
  localparam int FS_PGM_SUS = 2;
  localparam int FS_PROT    = 1;
  // Protocol encoding driven to the link logic.
  localparam logic [1:0] PROTO_EXT  = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;
  // Serial bus pins carried together.
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } fcfs_pins_t;
  // Events reported by the program and erase engine.
  typedef struct packed {
    logic busy;
    logic ers_sus;
    logic pgm_sus;
    logic ers_fail;
    logic pgm_fail;
    logic pgm_zero_to_one;
    logic vpp_bad;
    logic prot_err;
  } fcfs_evt_t;
endpackage : fcfs_pkg

// [src/fcfs_regs.sv]
// Enhanced volatile configuration and flag status registers behind the serial bus.
`timescale 1ns/1ps
`default_nettype none
module fcfs_regs (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                nrst,
  // Serial bus pins.
  input  wire fcfs_pkg::fcfs_pins_t pins,
  output logic                     miso_o,
  output logic                     miso_oe,
  // Program and erase engine.
  input  wire fcfs_pkg::fcfs_evt_t evt,
  input  wire logic                op_start,
  output logic                     op_reject,
  // Configuration outputs.
  output logic [1:0]               proto_o,
  output logic                     hold_en_o,
  output logic                     accel_en_o,
  output logic [2:0]               drv_o
);
  // Two-flop synchronisers for the pins.
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic       sclk_d_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r     <= 3'h2;
      s2_r     <= 3'h2;
      sclk_d_r <= 1'b0;
    end else begin
      s1_r     <= {pins.sclk, pins.cs_n, pins.mosi};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[2];
    end
  end
  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic rise;
  logic fall;
  assign sclk_s = s2_r[2];
  assign cs_n_s = s2_r[1];
  assign mosi_s = s2_r[0];
  assign rise   = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign fall   = ~sclk_s & sclk_d_r & ~cs_n_s;

  // Decide whether a stored value is a legal driver code.
  function automatic logic drv_ok(input logic [2:0] c);
    drv_ok = (c != fcfs_pkg::DRV_RSV_A) && (c != fcfs_pkg::DRV_RSV_B);
  endfunction : drv_ok

  // Shift register, bit counter and frame phase.
  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b100
  } fcfs_state_t;
  fcfs_state_t st_r;
  logic [7:0]  sh_r;
  logic [2:0]  cnt_r;
  logic [7:0]  op_r;
  logic [7:0]  sh_nxt;
  logic        byte_done;
  assign sh_nxt    = {sh_r[6:0], mosi_s};
  assign byte_done = rise && (cnt_r == 3'h7);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_r  <= 8'h00;
      cnt_r <= 3'h0;
    end else if (cs_n_s) begin
      cnt_r <= 3'h0;
    end else if (rise) begin
      sh_r  <= sh_nxt;
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // Frame phase: an opcode byte, then data in or data out.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_CMD;
      op_r <= 8'h00;
    end else if (cs_n_s) begin
      st_r <= ST_CMD;
    end else begin
      case (st_r)
        ST_CMD: begin
          if (byte_done) begin
            op_r <= sh_nxt;
            if (sh_nxt == fcfs_pkg::OP_READ_FLAG || sh_nxt == fcfs_pkg::OP_READ_EVCFG) begin
              st_r <= ST_READ;
            end else begin
              st_r <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // A data byte after a no-data opcode voids that opcode at frame end.
          if (byte_done) begin
            op_r <= 8'h00;
          end
        end
        ST_READ: st_r <= ST_READ;
        default: st_r <= ST_CMD;
      endcase
    end
  end

  // Frame-end command execution for opcodes without data.
  logic cs_n_d_r;
  logic frame_end;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_n_d_r <= 1'b1;
    end else begin
      cs_n_d_r <= cs_n_s;
    end
  end
  assign frame_end = cs_n_s & ~cs_n_d_r;

  // Write enable latch; a config write without it is dropped.
  logic wel_r;
  logic ev_wr;
  assign ev_wr = byte_done && (st_r == ST_DATA) && (op_r == fcfs_pkg::OP_WRITE_EVCFG)
                 && wel_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wel_r <= 1'b0;
    end else if (ev_wr) begin
      wel_r <= 1'b0;
    end else if (frame_end && st_r == ST_DATA && cnt_r == 3'h0) begin
      if (op_r == fcfs_pkg::OP_WRITE_EN) begin
        wel_r <= 1'b1;
      end else if (op_r == fcfs_pkg::OP_WRITE_DIS) begin
        wel_r <= 1'b0;
      end
    end
  end

  // Enhanced volatile configuration register; bit 5 reads as fixed zero.
  logic [7:0] ev_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev_r <= fcfs_pkg::EV_RESET;
    end else if (ev_wr) begin
      ev_r <= sh_nxt & ~(8'h01 << fcfs_pkg::EV_RSV_BIT);
    end
  end

  // Configuration outputs follow the register one clock cycle after it is written.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      proto_o    <= fcfs_pkg::PROTO_EXT;
      hold_en_o  <= 1'b1;
      accel_en_o <= 1'b0;
      drv_o      <= fcfs_pkg::DRV_DEFAULT;
    end else begin
      if (!ev_r[fcfs_pkg::EV_QUAD_BIT]) begin
        proto_o <= fcfs_pkg::PROTO_QUAD;
      end else if (!ev_r[fcfs_pkg::EV_DUAL_BIT]) begin
        proto_o <= fcfs_pkg::PROTO_DUAL;
      end else begin
        proto_o <= fcfs_pkg::PROTO_EXT;
      end
      hold_en_o  <= ev_r[fcfs_pkg::EV_HOLD_BIT];
      accel_en_o <= ~ev_r[fcfs_pkg::EV_ACCEL_BIT];
      if (drv_ok(ev_r[2:0])) begin
        drv_o <= ev_r[2:0];
      end else begin
        drv_o <= fcfs_pkg::DRV_DEFAULT;
      end
    end
  end

  // Sticky error flags; an event in the clearing cycle wins.
  logic clr_cmd;
  logic err_any;
  logic rej_evt;
  logic [3:0] err_r;
  assign clr_cmd = frame_end && st_r == ST_DATA && cnt_r == 3'h0
                   && op_r == fcfs_pkg::OP_CLEAR_FLAG;
  assign err_any = |err_r;
  assign rej_evt = op_start && err_any;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_r <= 4'h0;
    end else begin
      err_r[3] <= (err_r[3] & ~clr_cmd) | evt.ers_fail;
      err_r[2] <= (err_r[2] & ~clr_cmd) | evt.pgm_fail | evt.pgm_zero_to_one
                  | rej_evt;
      err_r[1] <= (err_r[1] & ~clr_cmd) | evt.vpp_bad;
      err_r[0] <= (err_r[0] & ~clr_cmd) | evt.prot_err;
    end
  end

  // Rejection pulse back to the engine.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_reject <= 1'b0;
    end else begin
      op_reject <= rej_evt;
    end
  end

  // Live flag status image; status bits follow the engine with no clear.
  logic [7:0] fs;
  assign fs = {~evt.busy, evt.ers_sus, err_r[3], err_r[2], err_r[1],
               evt.pgm_sus, err_r[0], 1'b0};

  // Read shifter: reloads the byte at each byte boundary, MSB first.
  logic [7:0] rd_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_r    <= 8'h00;
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
    end else if (cs_n_s) begin
      miso_oe <= 1'b0;
    end else if (byte_done && (st_r == ST_CMD || st_r == ST_READ)) begin
      if (st_r == ST_READ ? op_r == fcfs_pkg::OP_READ_FLAG
                          : sh_nxt == fcfs_pkg::OP_READ_FLAG) begin
        rd_r <= fs;
      end else begin
        rd_r <= ev_r;
      end
      miso_oe <= (st_r == ST_READ) || (sh_nxt == fcfs_pkg::OP_READ_FLAG)
                 || (sh_nxt == fcfs_pkg::OP_READ_EVCFG);
    end else if (fall && st_r == ST_READ) begin
      miso_o <= rd_r[~cnt_r];
    end
  end

  // Checks.
  a_quad_prio: assert property (@(posedge clk) disable iff (!nrst)
    !ev_r[fcfs_pkg::EV_QUAD_BIT] |=> proto_o == fcfs_pkg::PROTO_QUAD)
    else $error("quad not selected");
  a_drv_legal: assert property (@(posedge clk) disable iff (!nrst)
    drv_ok(drv_o))
    else $error("reserved driver code");
  sequence clr_seq;
    clr_cmd && !evt.ers_fail;
  endsequence
  a_err_clear: assert property (@(posedge clk) disable iff (!nrst)
    clr_seq |=> !err_r[3])
    else $error("erase error not cleared");
  a_err_sticky: assert property (@(posedge clk) disable iff (!nrst)
    err_r[3] && !clr_cmd |=> err_r[3])
    else $error("erase error lost");
  a_reject_err: assert property (@(posedge clk) disable iff (!nrst)
    op_start && err_any |=> op_reject && err_r[2])
    else $error("start with error not rejected");
  a_ready_busy: assert property (@(posedge clk) disable iff (!nrst)
    byte_done && st_r == ST_CMD && sh_nxt == fcfs_pkg::OP_READ_FLAG
    |=> rd_r[fcfs_pkg::FS_READY] == !$past(evt.busy))
    else $error("ready flag wrong");
  a_nowel_drop: assert property (@(posedge clk) disable iff (!nrst)
    !wel_r |=> $stable(ev_r))
    else $error("config written without enable");
  a_hold_follow: assert property (@(posedge clk) disable iff (!nrst)
    ##1 hold_en_o == $past(ev_r[fcfs_pkg::EV_HOLD_BIT]))
    else $error("hold enable mismatch");
endmodule : fcfs_regs
`default_nettype wire

// [testbench/fcfs_host.sv]
// Behavioural serial host that frames register commands toward the flash block.
`timescale 1ns/1ps
`default_nettype none
module fcfs_host (
  // Clock.
  input  wire logic                clk,
  // Serial pins.
  output var fcfs_pkg::fcfs_pins_t pins,
  input  wire logic                miso_o
);
  // Idle bus with chip select high and the link clock low.
  initial pins = 3'h2;
  // A link half period of four system cycles gives a 12.5 MHz link clock.
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  // Sends an opcode and an optional byte MSB first, capturing the byte returned.
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input bit two,
                       output logic [7:0] rx);
    logic [15:0] sr;
    sr = {op, dat};
    rx = 8'h00;
    @(negedge clk);
    pins.cs_n = 1'b0;
    for (int i = 0; i < (two ? 16 : 8); i++) begin
      pins.mosi = sr[15 - i];
      half();
      pins.sclk = 1'b1;
      rx = {rx[6:0], miso_o};
      half();
      pins.sclk = 1'b0;
    end
    half();
    pins.cs_n = 1'b1;
    pins.mosi = ~pins.mosi; // A released line must not keep its last value.
    repeat (8) @(negedge clk);
  endtask : frame
endmodule : fcfs_host
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the configuration and flag status registers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 clk, nrst, miso_o, miso_oe, op_start, op_reject, hold_en_o, accel_en_o;
  fcfs_pkg::fcfs_pins_t pins;
  fcfs_pkg::fcfs_evt_t  evt;
  logic [1:0]           proto_o;
  logic [2:0]           drv_o;
  logic [7:0]           rx;
  int                   err_count = 0;
  int                   total_checks = 0;
  int                   oe_cycles = 0;
  // Block under test and its serial host.
  fcfs_regs fcfs_regs_i (.clk(clk), .nrst(nrst), .pins(pins), .miso_o(miso_o),
    .miso_oe(miso_oe), .evt(evt), .op_start(op_start), .op_reject(op_reject),
    .proto_o(proto_o), .hold_en_o(hold_en_o), .accel_en_o(accel_en_o), .drv_o(drv_o));
  fcfs_host fcfs_host_i (.clk(clk), .pins(pins), .miso_o(miso_o));
  // Counts the cycles in which the block drives its data line.
  always @(negedge clk) begin
    if (miso_oe === 1'b1) begin
      oe_cycles++;
    end
  end
  // System clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compares one value and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // Configuration outputs packed into one byte.
  function automatic logic [7:0] outs();
    return {1'b0, proto_o, hold_en_o, accel_en_o, drv_o};
  endfunction : outs
  // Expected configuration outputs for a stored value.
  function automatic logic [7:0] exp_out(input logic [7:0] v);
    logic [1:0] p;
    logic [2:0] d;
    p = !v[7] ? fcfs_pkg::PROTO_QUAD : (!v[6] ? fcfs_pkg::PROTO_DUAL : fcfs_pkg::PROTO_EXT);
    d = (v[2:0] == 3'h0 || v[2:0] == 3'h4) ? 3'h7 : v[2:0];
    return {1'b0, p, v[4], ~v[3], d};
  endfunction : exp_out
  // Reads the flag status byte.
  task automatic rdf();
    fcfs_host_i.frame(8'h70, 8'h00, 1'b1, rx);
  endtask : rdf
  // Pulses an engine start and checks the refusal pulse.
  task automatic start(input logic exp);
    logic r1, r2;
    @(negedge clk);
    op_start = 1'b1;
    @(negedge clk);
    op_start = 1'b0;
    r1 = op_reject;
    @(negedge clk);
    r2 = op_reject;
    @(negedge clk);
    chk({6'h00, r1 | r2, op_reject}, {6'h00, exp, 1'b0});
  endtask : start
  // Reset values at the outputs and in the register.
  task automatic t_reset();
    int n;
    chk(outs(), exp_out(8'hdf));
    n = oe_cycles;
    fcfs_host_i.frame(8'h65, 8'h00, 1'b1, rx);
    chk(rx, 8'hdf);
    chk({7'h00, (oe_cycles - n) inside {[64:80]}}, 8'h01);
    chk({7'h00, miso_oe}, 8'h00);
  endtask : t_reset
  // Writes every protocol and driver code, with and without write enable.
  task automatic t_cfg();
    logic [7:0] tb [10] = '{8'hbf, 8'h7f, 8'h3f, 8'he9, 8'hd2, 8'hdb, 8'hdd, 8'hde, 8'hdc, 8'hd8};
    int n;
    fcfs_host_i.frame(8'h61, 8'h3f, 1'b1, rx);
    chk(outs(), exp_out(8'hdf));
    foreach (tb[i]) begin
      fcfs_host_i.frame(8'h06, 8'h00, 1'b0, rx);
      fcfs_host_i.frame(8'h61, tb[i], 1'b1, rx);
      chk(outs(), exp_out(tb[i]));
      fcfs_host_i.frame(8'h65, 8'h00, 1'b1, rx);
      chk(rx, tb[i] & 8'hdf);
    end
    fcfs_host_i.frame(8'h61, 8'hff, 1'b1, rx);
    chk(outs(), exp_out(8'hd8));
    n = oe_cycles;
    fcfs_host_i.frame(8'h06, 8'h00, 1'b0, rx);
    fcfs_host_i.frame(8'h04, 8'h00, 1'b0, rx);
    fcfs_host_i.frame(8'h61, 8'h00, 1'b1, rx);
    chk(outs(), exp_out(8'hd8));
    chk({7'h00, oe_cycles == n}, 8'h01);
  endtask : t_cfg
  // Status flags follow the engine and return idle on their own.
  task automatic t_status();
    logic [7:0] ev [3] = '{8'h80, 8'h40, 8'h20};
    logic [7:0] fs [3] = '{8'h00, 8'hc0, 8'h84};
    foreach (ev[i]) begin
      evt = ev[i];
      rdf();
      chk(rx, fs[i]);
    end
    evt = 8'h00;
    rdf();
    chk(rx, 8'h80);
  endtask : t_status
  // Error flags set, stick, refuse new work and clear by command.
  task automatic t_errors();
    logic [7:0] ev [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    logic [7:0] fs [5] = '{8'h20, 8'h10, 8'h10, 8'h08, 8'h02};
    start(1'b0);
    foreach (ev[i]) begin
      @(negedge clk);
      evt = ev[i];
      @(negedge clk);
      evt = 8'h00;
      rdf();
      chk(rx, 8'h80 | fs[i]);
      rdf();
      chk(rx, 8'h80 | fs[i]);
      start(1'b1);
      rdf();
      chk(rx, 8'h90 | fs[i]);
      fcfs_host_i.frame(8'h50, 8'h00, 1'b1, rx);
      rdf();
      chk(rx, 8'h90 | fs[i]);
      fcfs_host_i.frame(8'h50, 8'h00, 1'b0, rx);
      rdf();
      chk(rx, 8'h80);
    end
  endtask : t_errors
  // Main sequence.
  initial begin
    nrst = 1'b0;
    evt = 8'h00;
    op_start = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_cfg();
    t_status();
    t_errors();
    final_report();
  end
  // Watchdog well beyond the expected run time.
  initial begin
    #500000;
    err_count++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
